// ### logic/timer8_compare_waveform.sv
// 8-bit up/down timer with one compare unit, waveform output and APB registers
//
// Contract
// - Timer source is system clock, or crystal pin edges when async select is one.
// - Counter clears, counts up or down per mode; clock select zero stops it.
// - Counter readable and writable always; a processor write beats count or clear.
// - Waveform mode field picks counting sequence; overflow flag set where mode says.
// - Counter equal compare gives a match; compare flag sets at that timer tick.
// - Compare flag with its enable requests an interrupt; acknowledge clears flag.
// - Writing one to compare flag clears it; writing zero leaves it.
// - Compare value double buffered in PWM modes, direct in normal and clear modes.
// - Buffered compare value moves to active only at top or bottom.
// - Compare address reaches buffer when buffering, active register otherwise.
// - Force strobe in non-PWM modes acts on wave output only, no flag or reload.
// - A counter write blocks all matches in the following timer tick.
// - Wave output register keeps its value across mode changes.
// - Output action field is unbuffered; applies from first match after write.
// - Nonzero output action puts wave output on pin; direction stays with port.
// - Output action zero means no change of wave output at a match.
// - Output action never alters counting; picks polarity or set/clear/toggle.
// - Normal mode counts up only, no clear on match, wraps FF to 00.
// - Normal mode sets overflow as counter becomes zero; hardware only sets it.
// - Overflow interrupt acknowledge clears the overflow flag.
// - Clear mode resets counter to zero on match with compare value.
// - Fast PWM counts bottom to FF and restarts; clear on match, set at bottom.
// - Phase correct PWM counts up to FF then back down to bottom.
//
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
module timer8_compare_waveform (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic crystal_pin_in,
  output logic crystal_pin_out,
  input wire logic overflowIrqAck,
  input wire logic compareIrqAck,
  output logic overflowIrqReq,
  output logic compareIrqReq,
  input wire logic portOutValue,
  input wire logic wave_pin_direction,
  output logic wavePinOut,
  output logic wavePinOe_b
);
  import timer8_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] count_value;
    logic [7:0] compareActive;
    logic [7:0] compareBuffer;
    logic [2:0] clock_select_field;
    mode_t waveform_mode_field;
    logic [1:0] output_action_field;
    logic overflow_flag;
    logic compare_flag;
    logic overflowIrqEnable;
    logic compare_irq_enable;
    logic async_clock_select;
    logic countDown;
    logic countWritten;
    logic wave_output;
    logic [PRESC_W-1:0] presc;
    logic crystalPrev;
    logic ready;
    logic slvErr;
    logic [31:0] rdata;
    logic ovfReq;
    logic cmpReq;
    logic pinOut;
    logic pinOe_b;
    logic crystalOut;
  } state_t;

  state_t st_q;
  state_t st_d;

  logic wrEn;
  logic setupAcc;
  logic srcEdge;
  logic tick;
  logic isPwm;
  logic equal;
  logic matchOk;
  logic forceHit;
  logic mapped;

  // ---------------------------------------------------------------
  // Decode and tick
  // ---------------------------------------------------------------
  assign wrEn = psel && penable && st_q.ready && pwrite;
  assign setupAcc = psel && penable && !st_q.ready;
  assign mapped = (paddr == ADDR_COUNT) || (paddr == ADDR_COMPARE) ||
                  (paddr == ADDR_CONTROL) || (paddr == ADDR_FLAGS) ||
                  (paddr == ADDR_ENABLE);
  assign srcEdge = st_q.async_clock_select ? (crystal_pin_in && !st_q.crystalPrev) : 1'b1;
  assign tick = (st_q.clock_select_field != CS_STOPPED) && srcEdge &&
                ((st_q.presc & PRESC_MASK[st_q.clock_select_field]) ==
                 PRESC_MASK[st_q.clock_select_field]);
  assign isPwm = (st_q.waveform_mode_field == MODE_PHASE) ||
                 (st_q.waveform_mode_field == MODE_FAST);
  assign equal = (st_q.count_value == st_q.compareActive);
  assign matchOk = tick && equal && !st_q.countWritten;
  assign forceHit = wrEn && (paddr == ADDR_CONTROL) && pwdata[CTL_FORCE_BIT] && !isPwm;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;
    st_d.crystalPrev = crystal_pin_in;
    st_d.crystalOut = !crystal_pin_in;
    // Prescaler runs only while a clock is selected
    if (st_q.clock_select_field == CS_STOPPED)
    begin
      st_d.presc = '0;
    end
    else if (srcEdge)
    begin
      st_d.presc = st_q.presc + 1'b1;
    end
    if (tick)
    begin
      st_d.countWritten = 1'b0;
      case (st_q.waveform_mode_field)
        MODE_NORMAL:
        begin
          st_d.count_value = st_q.count_value + 1'b1;
          if (st_q.count_value == COUNT_MAX)
          begin
            st_d.overflow_flag = 1'b1;
          end
        end
        MODE_CTC:
        begin
          if (matchOk)
          begin
            st_d.count_value = COUNT_BOTTOM;
          end
          else
          begin
            st_d.count_value = st_q.count_value + 1'b1;
          end
          if (st_q.count_value == COUNT_MAX)
          begin
            st_d.overflow_flag = 1'b1;
          end
        end
        MODE_FAST:
        begin
          st_d.count_value = st_q.count_value + 1'b1;
          if (st_q.count_value == COUNT_MAX)
          begin
            st_d.overflow_flag = 1'b1;
            st_d.compareActive = st_q.compareBuffer;
            if (st_q.output_action_field == COM_CLEAR)
            begin
              st_d.wave_output = 1'b1;
            end
            else if (st_q.output_action_field == COM_SET)
            begin
              st_d.wave_output = 1'b0;
            end
          end
        end
        MODE_PHASE:
        begin
          if (st_q.countDown)
          begin
            st_d.count_value = st_q.count_value - 1'b1;
            if (st_q.count_value == 8'h01)
            begin
              st_d.overflow_flag = 1'b1;
              st_d.countDown = 1'b0;
            end
            else if (st_q.count_value == COUNT_BOTTOM)
            begin
              st_d.count_value = 8'h01;
              st_d.countDown = 1'b0;
            end
          end
          else if (st_q.count_value == COUNT_MAX)
          begin
            st_d.count_value = COUNT_MAX - 1'b1;
            st_d.countDown = 1'b1;
            st_d.compareActive = st_q.compareBuffer;
          end
          else
          begin
            st_d.count_value = st_q.count_value + 1'b1;
          end
        end
        default:
        begin
          st_d.count_value = st_q.count_value;
        end
      endcase
    end
    if (st_q.waveform_mode_field != MODE_PHASE)
    begin
      st_d.countDown = 1'b0;
    end
    // Wave output on match or force; action field read live
    if (matchOk || forceHit)
    begin
      if (!isPwm || forceHit)
      begin
        case (st_q.output_action_field)
          COM_TOGGLE: st_d.wave_output = !st_q.wave_output;
          COM_CLEAR: st_d.wave_output = 1'b0;
          COM_SET: st_d.wave_output = 1'b1;
          default: st_d.wave_output = st_q.wave_output;
        endcase
      end
      else if (st_q.output_action_field == COM_TOGGLE)
      begin
        if (st_q.waveform_mode_field == MODE_FAST)
        begin
          st_d.wave_output = !st_q.wave_output;
        end
      end
      else if (st_q.output_action_field != COM_NONE)
      begin
        // Clear on up-match for non-inverted, set on down-match
        st_d.wave_output = (st_q.output_action_field == COM_SET) ^ st_q.countDown;
      end
    end
    if (matchOk)
    begin
      st_d.compare_flag = 1'b1;
    end
    // Processor access
    st_d.ready = setupAcc;
    if (setupAcc)
    begin
      st_d.slvErr = !mapped;
      st_d.rdata = '0;
      case (paddr)
        ADDR_COUNT: st_d.rdata[7:0] = st_q.count_value;
        ADDR_COMPARE: st_d.rdata[7:0] = isPwm ? st_q.compareBuffer : st_q.compareActive;
        ADDR_CONTROL: st_d.rdata[6:0] = {st_q.output_action_field,
                                         st_q.waveform_mode_field, st_q.clock_select_field};
        ADDR_FLAGS: st_d.rdata[1:0] = {st_q.compare_flag, st_q.overflow_flag};
        ADDR_ENABLE: st_d.rdata[2:0] = {st_q.async_clock_select, st_q.compare_irq_enable,
                                        st_q.overflowIrqEnable};
        default: st_d.rdata = '0;
      endcase
    end
    if (wrEn)
    begin
      case (paddr)
        ADDR_COUNT:
        begin
          st_d.count_value = pwdata[7:0];
          st_d.countWritten = 1'b1;
        end
        ADDR_COMPARE:
        begin
          st_d.compareBuffer = pwdata[7:0];
          if (!isPwm)
          begin
            st_d.compareActive = pwdata[7:0];
          end
        end
        ADDR_CONTROL:
        begin
          st_d.clock_select_field = pwdata[CTL_CS_LSB +: 3];
          st_d.waveform_mode_field = mode_t'(pwdata[CTL_WGM_LSB +: 2]);
          st_d.output_action_field = pwdata[CTL_COM_LSB +: 2];
        end
        ADDR_FLAGS:
        begin
          // Write-one clears sit below the set terms, so a set wins
        end
        ADDR_ENABLE:
        begin
          st_d.overflowIrqEnable = pwdata[EN_OVF_BIT];
          st_d.compare_irq_enable = pwdata[EN_CMP_BIT];
          st_d.async_clock_select = pwdata[EN_ASYNC_BIT];
        end
        default:
        begin
          st_d.slvErr = st_q.slvErr;
        end
      endcase
    end
    // Clears by write-one or acknowledge; a same-cycle set wins
    if ((wrEn && (paddr == ADDR_FLAGS) && pwdata[FLG_OVF_BIT]) || overflowIrqAck)
    begin
      st_d.overflow_flag = st_d.overflow_flag && tick && (st_q.waveform_mode_field ==
                           MODE_PHASE ? (st_q.countDown && st_q.count_value == 8'h01) :
                           (st_q.count_value == COUNT_MAX));
    end
    if ((wrEn && (paddr == ADDR_FLAGS) && pwdata[FLG_CMP_BIT]) || compareIrqAck)
    begin
      st_d.compare_flag = matchOk;
    end
    st_d.ovfReq = st_d.overflow_flag && st_d.overflowIrqEnable;
    st_d.cmpReq = st_d.compare_flag && st_d.compare_irq_enable;
    st_d.pinOut = (st_d.output_action_field != COM_NONE) ? st_d.wave_output :
                  portOutValue;
    st_d.pinOe_b = !wave_pin_direction;
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_q <= '0;
      st_q.pinOe_b <= 1'b1;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign prdata = st_q.rdata;
  assign pready = st_q.ready;
  assign pslverr = st_q.slvErr;
  assign crystal_pin_out = st_q.crystalOut;
  assign overflowIrqReq = st_q.ovfReq;
  assign compareIrqReq = st_q.cmpReq;
  assign wavePinOut = st_q.pinOut;
  assign wavePinOe_b = st_q.pinOe_b;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence s_write(logic [7:0] addr);
    wrEn && (paddr == addr);
  endsequence

  property p_stopped;
    @(posedge clk_sys) disable iff (!rst_b)
    (st_q.clock_select_field == CS_STOPPED) && !(wrEn && (paddr == ADDR_COUNT)) |=>
      $stable(st_q.count_value);
  endproperty
  a_stopped: assert property (p_stopped) else $error("counter moved while stopped");

  property p_count_write;
    @(posedge clk_sys) disable iff (!rst_b)
    s_write(ADDR_COUNT) |=> (st_q.count_value == $past(pwdata[7:0])) && st_q.countWritten;
  endproperty
  a_count_write: assert property (p_count_write) else $error("count write lost");

  property p_match_flag;
    @(posedge clk_sys) disable iff (!rst_b)
    matchOk && !compareIrqAck && !(wrEn && (paddr == ADDR_FLAGS)) |=> st_q.compare_flag;
  endproperty
  a_match_flag: assert property (p_match_flag) else $error("match did not set flag");

  property p_block;
    @(posedge clk_sys) disable iff (!rst_b)
    st_q.countWritten && tick && !st_q.compare_flag |=> !st_q.compare_flag;
  endproperty
  a_block: assert property (p_block) else $error("match not blocked after write");

  property p_normal_wrap;
    @(posedge clk_sys) disable iff (!rst_b)
    tick && (st_q.waveform_mode_field == MODE_NORMAL) && (st_q.count_value == COUNT_MAX) &&
      !wrEn |=> (st_q.count_value == COUNT_BOTTOM) && st_q.overflow_flag;
  endproperty
  a_normal_wrap: assert property (p_normal_wrap) else $error("normal wrap wrong");

  property p_w1c;
    @(posedge clk_sys) disable iff (!rst_b)
    s_write(ADDR_FLAGS) ##0 (pwdata[FLG_CMP_BIT] && !matchOk) |=> !st_q.compare_flag;
  endproperty
  a_w1c: assert property (p_w1c) else $error("compare flag not cleared");

  property p_force;
    @(posedge clk_sys) disable iff (!rst_b)
    forceHit && !tick && (st_q.output_action_field == COM_TOGGLE) |=>
      (st_q.wave_output != $past(st_q.wave_output)) && $stable(st_q.compare_flag);
  endproperty
  a_force: assert property (p_force) else $error("force strobe wrong");

  property p_pin;
    @(posedge clk_sys) disable iff (!rst_b)
    (st_q.output_action_field != COM_NONE) |-> wavePinOut == st_q.wave_output;
  endproperty
  a_pin: assert property (p_pin) else $error("pin not from wave output");

  property p_buffer;
    @(posedge clk_sys) disable iff (!rst_b)
    s_write(ADDR_COMPARE) ##0 (isPwm && !tick) |=>
      $stable(st_q.compareActive) && (st_q.compareBuffer == $past(pwdata[7:0]));
  endproperty
  a_buffer: assert property (p_buffer) else $error("buffered compare leaked");

  property p_ctc_clear;
    @(posedge clk_sys) disable iff (!rst_b)
    matchOk && (st_q.waveform_mode_field == MODE_CTC) && !wrEn |=>
      st_q.count_value == COUNT_BOTTOM;
  endproperty
  a_ctc_clear: assert property (p_ctc_clear) else $error("clear mode missed");

  property p_phase_top;
    @(posedge clk_sys) disable iff (!rst_b)
    tick && (st_q.waveform_mode_field == MODE_PHASE) && !st_q.countDown &&
      (st_q.count_value == COUNT_MAX) && !wrEn |=>
      (st_q.count_value == COUNT_MAX - 8'h01) && st_q.countDown;
  endproperty
  a_phase_top: assert property (p_phase_top) else $error("phase top turn wrong");
endmodule : timer8_compare_waveform

// ### logic/timer8_pkg.sv
// Constants and types for the 8-bit timer with compare and waveform output
package timer8_pkg;
  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_COUNT = 8'h00;
  localparam logic [7:0] ADDR_COMPARE = 8'h04;
  localparam logic [7:0] ADDR_CONTROL = 8'h08;
  localparam logic [7:0] ADDR_FLAGS = 8'h0C;
  localparam logic [7:0] ADDR_ENABLE = 8'h10;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CTL_CS_LSB = 0;
  localparam int CTL_WGM_LSB = 3;
  localparam int CTL_COM_LSB = 5;
  localparam int CTL_FORCE_BIT = 7;
  localparam int FLG_OVF_BIT = 0;
  localparam int FLG_CMP_BIT = 1;
  localparam int EN_OVF_BIT = 0;
  localparam int EN_CMP_BIT = 1;
  localparam int EN_ASYNC_BIT = 2;
  // ---------------------------------------------------------------
  // Values
  // ---------------------------------------------------------------
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [2:0] CS_STOPPED = 3'h0;
  localparam logic [1:0] COM_NONE = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;
  localparam int PRESC_W = 10;
  // Prescaler masks for clock select 1..7 (divide by 1,8,32,64,128,256,1024)
  localparam logic [PRESC_W-1:0] PRESC_MASK [8] = '{
    10'h000, 10'h000, 10'h007, 10'h01F, 10'h03F, 10'h07F, 10'h0FF, 10'h3FF};

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_PHASE = 2'b01,
    MODE_CTC = 2'b10,
    MODE_FAST = 2'b11
  } mode_t;
endpackage : timer8_pkg

// ### verif/cpu_bus_model.sv
// Processor-side model: APB register access and interrupt acknowledge
`timescale 1ns/1ps
module cpu_bus_model (
  input wire logic clk_sys,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic overflowIrqAck,
  output logic compareIrqAck
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    overflowIrqAck = 1'b0;
    compareIrqAck = 1'b0;
  end

  // One APB transfer; the request stands until pready is sampled high
  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] data,
                      output logic [31:0] rdata, output logic err);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
      @(posedge clk_sys);
    while (pready !== 1'b1);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released bus shows no stale values
    paddr <= ~addr;
    pwdata <= ~data;
  endtask : xfer

  // Interrupt taken by the core: one-cycle acknowledge
  task automatic ack(input logic ovf);
    @(posedge clk_sys);
    overflowIrqAck <= ovf;
    compareIrqAck <= ~ovf;
    @(posedge clk_sys);
    overflowIrqAck <= 1'b0;
    compareIrqAck <= 1'b0;
  endtask : ack
endmodule : cpu_bus_model

// ### verif/tb_top.sv
// Self-checking bench for the 8-bit compare timer
`timescale 1ns/1ps
module tb_top;
  import timer8_pkg::*;
  logic clk_sys, rst_b, psel, penable, pwrite, pready, pslverr, crystalIn, crystalOut;
  logic ovfAck, cmpAck, ovfReq, cmpReq, portOut, pinDir, pinOut, pinOe_b, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int fails = 0;
  int nCompared = 0;
  logic [1:0] comTab [3] = '{2'h3, 2'h2, 2'h1};
  logic expTab [3] = '{1'b1, 1'b0, 1'b1};

  timer8_compare_waveform DUT (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .crystal_pin_in(crystalIn),
    .crystal_pin_out(crystalOut), .overflowIrqAck(ovfAck), .compareIrqAck(cmpAck),
    .overflowIrqReq(ovfReq), .compareIrqReq(cmpReq), .portOutValue(portOut),
    .wave_pin_direction(pinDir), .wavePinOut(pinOut), .wavePinOe_b(pinOe_b));
  cpu_bus_model HOST (.clk_sys(clk_sys), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .overflowIrqAck(ovfAck), .compareIrqAck(cmpAck));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    HOST.xfer(1'b1, a, {24'h00_0000, d}, rd, err);
  endtask : wr

  task automatic chk(input logic [7:0] a, input logic [31:0] exp);
    HOST.xfer(1'b0, a, 32'h0000_0000, rd, err);
    check(rd, exp);
  endtask : chk

  task automatic ctl(input logic [2:0] cs, input logic [1:0] wgm, input logic [1:0] com,
                     input logic frc);
    wr(ADDR_CONTROL, {frc, com, wgm, cs});
  endtask : ctl

  // Run the timer at full rate for a number of cycles, then stop it
  task automatic run(input logic [1:0] wgm, input int cycles);
    ctl(3'h1, wgm, 2'h0, 1'b0);
    repeat (cycles) @(posedge clk_sys);
    ctl(3'h0, wgm, 2'h0, 1'b0);
  endtask : run

  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", nCompared, fails);
    if (fails == 0 && nCompared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : print_verdict

  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  initial
  begin
    #(20000 * 100);
    fails++;
    print_verdict();
  end

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial
  begin
    rst_b = 1'b0;
    crystalIn = 1'b0;
    portOut = 1'b0;
    pinDir = 1'b0;
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    check(32'(pinOe_b), 32'h0000_0001);
    check(32'(pinOut), 32'h0000_0000);
    for (int i = 0; i < 5; i++)
      chk(8'(4 * i), 32'h0000_0000);
    chk(8'h14, 32'h0000_0000);
    check(32'(err), 32'h0000_0001);
    // Counter access while stopped
    wr(ADDR_COUNT, 8'h5A);
    repeat (20) @(posedge clk_sys);
    chk(ADDR_COUNT, 32'h0000_005A);
    // Count write equal to compare gives no match
    wr(ADDR_COMPARE, 8'h20);
    wr(ADDR_COUNT, 8'h20);
    run(2'h0, 20);
    chk(ADDR_FLAGS, 32'h0000_0000);
    // Normal mode wrap sets overflow only
    wr(ADDR_COMPARE, 8'h80);
    wr(ADDR_COUNT, 8'hF0);
    run(2'h0, 40);
    chk(ADDR_FLAGS, 32'h0000_0001);
    HOST.xfer(1'b0, ADDR_COUNT, 32'h0000_0000, rd, err);
    check(32'(rd < 32'h0000_0040), 32'h0000_0001);
    wr(ADDR_FLAGS, 8'h00);
    chk(ADDR_FLAGS, 32'h0000_0001);
    wr(ADDR_ENABLE, 8'h01);
    repeat (2) @(posedge clk_sys);
    check(32'(ovfReq), 32'h0000_0001);
    HOST.ack(1'b1);
    repeat (2) @(posedge clk_sys);
    chk(ADDR_FLAGS, 32'h0000_0000);
    // Compare match
    wr(ADDR_COUNT, 8'h7C);
    run(2'h0, 20);
    chk(ADDR_FLAGS, 32'h0000_0002);
    wr(ADDR_ENABLE, 8'h02);
    repeat (2) @(posedge clk_sys);
    check(32'(cmpReq), 32'h0000_0001);
    HOST.ack(1'b0);
    repeat (2) @(posedge clk_sys);
    chk(ADDR_FLAGS, 32'h0000_0000);
    wr(ADDR_COUNT, 8'h7C);
    run(2'h0, 20);
    wr(ADDR_FLAGS, 8'h03);
    chk(ADDR_FLAGS, 32'h0000_0000);
    // Clear on match bounds the count
    wr(ADDR_COMPARE, 8'h08);
    wr(ADDR_COUNT, 8'h00);
    run(2'h2, 100);
    HOST.xfer(1'b0, ADDR_COUNT, 32'h0000_0000, rd, err);
    check(32'(rd <= 32'h0000_0008), 32'h0000_0001);
    chk(ADDR_FLAGS, 32'h0000_0002);
    wr(ADDR_FLAGS, 8'h03);
    // Compare buffering
    wr(ADDR_COMPARE, 8'h10);
    ctl(3'h0, 2'h3, 2'h0, 1'b0);
    wr(ADDR_COMPARE, 8'h40);
    chk(ADDR_COMPARE, 32'h0000_0040);
    ctl(3'h0, 2'h0, 2'h0, 1'b0);
    chk(ADDR_COMPARE, 32'h0000_0010);
    run(2'h3, 300);
    ctl(3'h0, 2'h0, 2'h0, 1'b0);
    chk(ADDR_COMPARE, 32'h0000_0040);
    // Forced compare drives the wave output
    wr(ADDR_COUNT, 8'h33);
    wr(ADDR_FLAGS, 8'h03);
    for (int i = 0; i < 3; i++)
    begin
      ctl(3'h0, 2'h0, comTab[i], 1'b0);
      ctl(3'h0, 2'h0, comTab[i], 1'b1);
      pinDir <= 1'b1;
      repeat (3) @(posedge clk_sys);
      check(32'(pinOe_b), 32'h0000_0000);
      check(32'(pinOut), 32'(expTab[i]));
    end
    chk(ADDR_FLAGS, 32'h0000_0000);
    chk(ADDR_COUNT, 32'h0000_0033);
    ctl(3'h0, 2'h2, 2'h1, 1'b0);
    repeat (3) @(posedge clk_sys);
    check(32'(pinOut), 32'h0000_0001);
    ctl(3'h0, 2'h2, 2'h0, 1'b0);
    ctl(3'h0, 2'h2, 2'h0, 1'b1);
    repeat (3) @(posedge clk_sys);
    check(32'(pinOut), 32'h0000_0000);
    ctl(3'h0, 2'h2, 2'h1, 1'b0);
    repeat (3) @(posedge clk_sys);
    check(32'(pinOut), 32'h0000_0001);
    // Crystal pin as timer source
    wr(ADDR_COUNT, 8'h00);
    wr(ADDR_ENABLE, 8'h04);
    ctl(3'h1, 2'h0, 2'h0, 1'b0);
    repeat (5)
    begin
      crystalIn <= 1'b1;
      repeat (4) @(posedge clk_sys);
      crystalIn <= 1'b0;
      repeat (4) @(posedge clk_sys);
    end
    repeat (6) @(posedge clk_sys);
    check(32'(crystalOut), 32'h0000_0001);
    ctl(3'h0, 2'h0, 2'h0, 1'b0);
    chk(ADDR_COUNT, 32'h0000_0005);
    // Dual-slope count turns at the top
    wr(ADDR_ENABLE, 8'h00);
    wr(ADDR_COUNT, 8'hFC);
    run(2'h1, 4);
    chk(ADDR_COUNT, 32'h0000_00FA);
    print_verdict();
  end
endmodule : tb_top
